// file: tb/data_bus_remote_access_timing_tb_top.sv
// Self-checking bench for the bus timing and remote access block
`include "dbra_map.vh"
`default_nettype none
module data_bus_remote_access_timing_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk_sys = 1'b0;
   logic        i_nrst = 1'b1;
   logic [2:0]  reg_addr = 3'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        cpu_req = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic        remote_read_strobe_n = 1'b1;
   logic        remote_write_strobe_n = 1'b1;
   logic        cfg_sel = 1'b0;
   logic [7:0]  rem_wd = 8'h00;
   wire  [7:0]  reg_rdata, cpu_data, a_out, ad_out, ad_pins, rem_data;
   wire  [15:0] instr_addr, instr_wdata, instr_rdata;
   wire         cpu_done, a_oe, ad_oe, ale, read_n, grant, rem_oe, iwr_n;
   int          n_mismatch = 0;
   int          compares = 0;
   int          seed = 76644;
   int          n;
   logic [7:0]  v;
   logic [15:0] a;
   dbra_core uut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_cpu_rd_req(cpu_req),
      .i_cpu_addr(cpu_addr), .o_cpu_rd_data(cpu_data), .o_cpu_rd_done(cpu_done), .o_a_out(a_out),
      .o_a_oe(a_oe), .o_ad_out(ad_out), .o_ad_oe(ad_oe), .i_ad_in(ad_pins), .o_ale(ale), .o_read_n(read_n),
      .o_local_bus_grant(grant), .i_remote_read_n(remote_read_strobe_n), .i_remote_write_n(remote_write_strobe_n),
      .i_remote_cfg_sel(cfg_sel), .i_remote_data(rem_wd), .o_remote_data(rem_data),
      .o_remote_data_oe(rem_oe), .o_instr_addr(instr_addr), .o_instr_wdata(instr_wdata),
      .o_instr_write_n(iwr_n), .i_instr_rdata(instr_rdata));
   dbra_dmem_model u_mem (.i_clk_sys(i_clk_sys), .i_a(a_out), .i_ad(ad_out), .i_ad_oe(ad_oe),
      .i_ale(ale), .i_read_n(read_n), .o_pins(ad_pins));
   assign instr_rdata = instr_addr ^ 16'hc3a5;
   always #20 i_clk_sys = ~i_clk_sys;
   function automatic logic [7:0] dm(input logic [15:0] x);
      return x[15:8] ^ x[7:0] ^ 8'h96;
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge i_clk_sys);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] ad, input logic [7:0] e);
      @(posedge i_clk_sys);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic lrd(input logic [15:0] ad, input logic lng);
      @(posedge i_clk_sys);
      cpu_addr <= ad;
      cpu_req <= 1'b1;
      n = 0;
      while (cpu_done !== 1'b1) begin
         tick(1);
         n++;
         if (n > 30) begin
            n_mismatch++;
            tally_and_finish();
         end
      end
      chk("rd_len", 16'(n), lng ? 16'd9 : 16'd7);
      chk("rd_data", {8'h00, cpu_data}, {8'h00, dm(ad)});
      cpu_req <= 1'b0;
      tick(2);
   endtask
   // Remote host: code and counter touched only while no local read runs
   task automatic rrd(input logic sel, input logic [7:0] e);
      @(posedge i_clk_sys);
      cfg_sel <= sel;
      remote_read_strobe_n <= 1'b0;
      tick(5);
      chk("rem_data", {7'h00, rem_oe, rem_data}, {8'h01, e});
      @(posedge i_clk_sys);
      remote_read_strobe_n <= 1'b1;
      tick(5);
   endtask
   task automatic rwr(input logic sel, input logic [7:0] d);
      @(posedge i_clk_sys);
      cfg_sel <= sel;
      rem_wd <= d;
      remote_write_strobe_n <= 1'b0;
      tick(4);
      @(posedge i_clk_sys);
      remote_write_strobe_n <= 1'b1;
      tick(9);
   endtask
   initial begin
      i_nrst <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      #1;
      chk("a_ad", {a_out, ad_out}, 16'h0000);
      rd(`DBRA_OFS_ACR, 8'h00);
      rd(`DBRA_OFS_IDX0, 8'h00);
      rd(`DBRA_OFS_IDX1, 8'h00);
      rd(`DBRA_OFS_RIC, 8'h00);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      lrd(16'h0000, 1'b0);
      $display("Test reset done");
      @(posedge i_clk_sys);
      cfg_sel <= 1'b0;
      remote_read_strobe_n <= 1'b0;
      tick(6);
      chk("remote_owns", {14'h0, a_oe, grant}, 16'h0000);
      @(posedge i_clk_sys);
      remote_read_strobe_n <= 1'b1;
      tick(6);
      chk("local_owns", {14'h0, a_oe, grant}, 16'h0003);
      $display("Test handover done");
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         a = 16'($random(seed));
         wr(`DBRA_OFS_ACR, {7'h00, v[0]});
         wr(i[0] ? `DBRA_OFS_IDX1 : `DBRA_OFS_IDX0, v);
         rd(i[0] ? `DBRA_OFS_IDX1 : `DBRA_OFS_IDX0, v);
         lrd(a, v[0]);
      end
      wr(`DBRA_OFS_ACR, 8'h01);
      lrd(16'hffff, 1'b1);
      wr(`DBRA_OFS_ACR, 8'h00);
      lrd(16'h00ff, 1'b0);
      $display("Test local reads done");
      rwr(1'b1, 8'h02);
      rrd(1'b1, 8'h02);
      rwr(1'b0, 8'h34);
      rwr(1'b1, 8'h03);
      rwr(1'b0, 8'h12);
      chk("counter", instr_addr, 16'h1234);
      rrd(1'b0, 8'h12);
      rwr(1'b1, 8'h02);
      rrd(1'b0, 8'h34);
      rwr(1'b1, 8'h01);
      rrd(1'b0, 8'h91);
      rrd(1'b0, 8'hd1);
      chk("counter", instr_addr, 16'h1235);
      rwr(1'b1, 8'h01);
      rwr(1'b0, 8'haa);
      rwr(1'b0, 8'h55);
      chk("code_wdata", instr_wdata, 16'h55aa);
      chk("counter", instr_addr, 16'h1236);
      rrd(1'b0, 8'h93);
      rwr(1'b1, 8'h01);
      rrd(1'b0, 8'h93);
      $display("Test remote done");
      @(posedge i_clk_sys);
      i_nrst <= 1'b0;
      tick(3);
      @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      rd(`DBRA_OFS_RIC, 8'h00);
      lrd(16'h5a5a, 1'b0);
      $display("Test second reset done");
      tally_and_finish();
   end
endmodule // data_bus_remote_access_timing_tb_top
`default_nettype wire

// file: tb/dbra_dmem_model.sv
// Static data memory on the multiplexed bus
`default_nettype none
module dbra_dmem_model (
   input  wire logic       i_clk_sys, // Clock
   input  wire logic [7:0] i_a,       // Address high byte
   input  wire logic [7:0] i_ad,      // Device bus value
   input  wire logic       i_ad_oe,   // Device drives bus
   input  wire logic       i_ale,     // Address latch strobe
   input  wire logic       i_read_n,  // Read strobe
   output var  logic [7:0] o_pins     // Bus level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] adr_ff;
   logic [7:0]  last_ff = 8'h00;
   always_ff @(posedge i_clk_sys) begin
      if (i_ale) adr_ff <= {i_a, i_ad};
      last_ff <= o_pins;
   end
   // Undriven bus toggles so a stale value never looks valid
   always_comb begin
      if (i_ad_oe) o_pins = i_ad;
      else if (!i_read_n) o_pins = adr_ff[15:8] ^ adr_ff[7:0] ^ 8'h96;
      else o_pins = ~last_ff;
   end
endmodule // dbra_dmem_model
`default_nettype wire

// file: tb/dbra_props.sv
// Port-level timing checks for the bus timing and remote access block
`include "dbra_map.vh"
`default_nettype none
module dbra_props (
   input wire logic        i_clk_sys,         // Clock
   input wire logic        i_nrst,            // Reset, active low
   input wire logic [2:0]  i_reg_addr,        // Register address
   input wire logic [7:0]  i_reg_wdata,       // Register write data
   input wire logic        i_reg_wr,          // Register write
   input wire logic        i_reg_rd,          // Register read
   input wire logic [7:0]  o_reg_rdata,       // Register read data
   input wire logic [7:0]  o_a_out,           // Address high byte
   input wire logic        o_a_oe,            // Address drive
   input wire logic [7:0]  o_ad_out,          // Muxed bus out
   input wire logic        o_ad_oe,           // Muxed bus drive
   input wire logic        o_ale,             // Address latch strobe
   input wire logic        o_read_n,          // Read strobe
   input wire logic        o_local_bus_grant, // Local grant
   input wire logic        i_remote_read_n,   // Remote read strobe
   input wire logic        i_remote_write_n,  // Remote write strobe
   input wire logic        o_remote_data_oe,  // Remote data drive
   input wire logic [15:0] o_instr_addr,      // Program counter
   input wire logic        o_instr_write_n    // Code write strobe
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   logic long_ff;
   // Mirror of the long-read select bit
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) long_ff <= 1'b0;
      else if (i_reg_wr && i_reg_addr == `DBRA_OFS_ACR) long_ff <= i_reg_wdata[`DBRA_ACR_LONG_RD];
   end
   property p_fast_stb; $fell(o_ale) && !long_ff |-> $fell(o_read_n); endproperty
   a_fast_stb: assert property (p_fast_stb) else $error("fast read strobe late");
   property p_long_stb; $fell(o_ale) && long_ff |-> o_read_n ##1 $fell(o_read_n); endproperty
   a_long_stb: assert property (p_long_stb) else $error("long read strobe not delayed");
   property p_fast_len; $fell(o_read_n) && !long_ff |-> !o_read_n [*4] ##1 o_read_n; endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast read length wrong");
   property p_long_len; $fell(o_read_n) && long_ff |-> !o_read_n [*5] ##1 o_read_n; endproperty
   a_long_len: assert property (p_long_len) else $error("long read length wrong");
   property p_ad_gap; (!o_read_n || $rose(o_read_n)) |-> !o_ad_oe; endproperty
   a_ad_gap: assert property (p_ad_gap) else $error("bus driven too soon after read");
   property p_give; $fell(o_a_oe) |-> !o_ad_oe && !o_local_bus_grant; endproperty
   a_give: assert property (p_give) else $error("handover not undriven");
   property p_take; $rose(o_a_oe) |-> $past(i_remote_read_n, 2) && $past(i_remote_write_n, 2); endproperty
   a_take: assert property (p_take) else $error("bus retaken while remote active");
   property p_grant; o_remote_data_oe && $past(i_remote_read_n, 2) |-> !o_local_bus_grant; endproperty
   a_grant: assert property (p_grant) else $error("grant kept after remote read end");
   property p_softld;
      $fell(o_instr_write_n) |-> ##1 !o_instr_write_n && $stable(o_instr_addr)
         ##1 o_instr_write_n ##1 o_instr_addr == $past(o_instr_addr) + 16'h0001;
   endproperty
   a_softld: assert property (p_softld) else $error("soft load address step wrong");
   property p_acr_rd; $past(i_reg_rd) && $past(i_reg_addr) == `DBRA_OFS_ACR |-> o_reg_rdata == {7'h00, long_ff}; endproperty
   a_acr_rd: assert property (p_acr_rd) else $error("long-read select readback wrong");
   property p_rst_zero; disable iff (1'b0) !i_nrst |-> o_a_out == 8'h00 && o_ad_out == 8'h00 && !o_ad_oe; endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("bus value not zero in reset");
endmodule // dbra_props
bind dbra_core dbra_props u_props (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .o_a_out(o_a_out), .o_a_oe(o_a_oe), .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe), .o_ale(o_ale),
   .o_read_n(o_read_n), .o_local_bus_grant(o_local_bus_grant), .i_remote_read_n(i_remote_read_n),
   .i_remote_write_n(i_remote_write_n), .o_remote_data_oe(o_remote_data_oe),
   .o_instr_addr(o_instr_addr), .o_instr_write_n(o_instr_write_n));
`default_nettype wire

// file: verilog/dbra_core.v
// External bus timing, arbitration and remote access for data and instruction memory
`include "dbra_map.vh"
`default_nettype none
module dbra_core (
   input  wire        i_clk_sys,          // System clock, 25 MHz
   input  wire        i_nrst,             // Async reset, active low
   input  wire [2:0]  i_reg_addr,         // Register address
   input  wire [7:0]  i_reg_wdata,        // Register write data
   input  wire        i_reg_wr,           // Register write strobe
   input  wire        i_reg_rd,           // Register read strobe
   output reg  [7:0]  o_reg_rdata,        // Register read data, cycle after strobe
   input  wire        i_cpu_rd_req,       // Local data memory read request, held to done
   input  wire [15:0] i_cpu_addr,         // Local data memory address
   output reg  [7:0]  o_cpu_rd_data,      // Local read data
   output reg         o_cpu_rd_done,      // Local read done pulse
   output reg  [7:0]  o_a_out,            // Address bus, high byte
   output reg         o_a_oe,             // Address bus drive enable
   output reg  [7:0]  o_ad_out,           // Multiplexed address/data bus out
   output reg         o_ad_oe,            // Multiplexed bus drive enable
   input  wire [7:0]  i_ad_in,            // Multiplexed bus pins in
   output reg         o_ale,              // Address latch strobe
   output reg         o_read_n,           // Data memory read strobe, active low
   output wire        o_local_bus_grant,  // Local bus grant
   input  wire        i_remote_read_n,    // Remote read strobe, active low
   input  wire        i_remote_write_n,   // Remote write strobe, active low
   input  wire        i_remote_cfg_sel,   // Remote targets the configuration register
   input  wire [7:0]  i_remote_data,      // Remote data in
   output reg  [7:0]  o_remote_data,      // Remote data out
   output reg         o_remote_data_oe,   // Remote data drive enable
   output reg  [15:0] o_instr_addr,       // Instruction address bus (program counter)
   output reg  [15:0] o_instr_wdata,      // Instruction write data
   output reg         o_instr_write_n,    // Instruction write strobe, active low
   input  wire [15:0] i_instr_rdata       // Instruction memory read data
);
   // ==================================================
   // States
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_LRD  = 6'h02;
   localparam [5:0] ST_LGAP = 6'h04;
   localparam [5:0] ST_RGAP = 6'h08;
   localparam [5:0] ST_REM  = 6'h10;
   localparam [5:0] ST_HGAP = 6'h20;
   localparam [3:0] HC      = `DBRA_HALF_T_CYC;
   localparam [3:0] FAST_LAST = `DBRA_FAST_RD_HALVES * HC - 4'h1;
   localparam [3:0] LONG_LAST = `DBRA_LONG_RD_HALVES * HC - 4'h1;
   localparam [3:0] ALE_CYC   = `DBRA_ALE_HALVES * HC;
   localparam [3:0] IWR_CYC   = `DBRA_IWR_HALVES * HC;
   localparam [3:0] SL_CYC    = `DBRA_SOFTLD_HALVES * HC;

   // ==================================================
   // Pin synchronisers
   wire [18:0] sync_q;
   dbra_sync #(.W(19), .RST(1'b0)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_d       ({~i_remote_read_n, ~i_remote_write_n, i_remote_cfg_sel, i_remote_data, i_ad_in}),
      .o_q       (sync_q)
   );
   wire       rrd_s  = sync_q[18];
   wire       rwr_s  = sync_q[17];
   wire       cfg_s  = sync_q[16];
   wire [7:0] rdat_s = sync_q[15:8];
   wire [7:0] ad_s   = sync_q[7:0];

   // ==================================================
   // Registers
   reg [5:0]  state_ff;
   reg [5:0]  nxt_state;
   reg [3:0]  ph_ff;
   reg [3:0]  nxt_ph;
   reg        long_ff;
   reg        last_rem_ff;
   reg [7:0]  acr_ff;
   reg [7:0]  idx0_ff;
   reg [7:0]  idx1_ff;
   reg [7:0]  ric_ff;
   reg        rrd_d_ff;
   reg        rwr_d_ff;
   reg        buf_rd_ff;
   reg        byte_hi_ff;
   reg [7:0]  wlo_ff;
   reg [3:0]  iwr_cnt_ff;
   reg [3:0]  sl_cnt_ff;

   wire [1:0] ms        = ric_ff[1:0];
   wire       rem_dm_req = (rrd_s | rwr_s) & ~cfg_s & (ms == `DBRA_MS_DMEM);
   wire       long_sel  = (state_ff == ST_IDLE) ? acr_ff[`DBRA_ACR_LONG_RD] : long_ff;
   wire [3:0] rd_last   = long_sel ? LONG_LAST : FAST_LAST;
   wire [3:0] rd_fall   = long_sel ? ALE_CYC + HC : ALE_CYC;
   wire       rrd_fall  = rrd_s & ~rrd_d_ff;
   wire       rrd_rise  = ~rrd_s & rrd_d_ff;
   wire       rwr_rise  = ~rwr_s & rwr_d_ff;
   wire       buf_sel   = cfg_s | (ms != `DBRA_MS_DMEM);

   // Grant drops at once when a buffered read strobe ends
   assign o_local_bus_grant = o_a_oe & ~(buf_rd_ff & ~rrd_s);

   // ==================================================
   // Bus ownership and local read sequencer
   always @* begin
      nxt_state = state_ff;
      nxt_ph    = ph_ff;
      case (state_ff)
         ST_IDLE: begin
            if (i_cpu_rd_req && (!rem_dm_req || last_rem_ff)) begin
               nxt_state = ST_LRD;
               nxt_ph    = 4'h0;
            end else if (rem_dm_req) begin
               nxt_state = ST_RGAP;
            end
         end
         ST_LRD: begin
            if (ph_ff == rd_last) begin
               nxt_state = ST_LGAP;
            end else begin
               nxt_ph = ph_ff + 4'h1;
            end
         end
         ST_LGAP: nxt_state = ST_IDLE;
         ST_RGAP: nxt_state = ST_REM;
         ST_REM: begin
            if (!rem_dm_req) begin
               nxt_state = ST_HGAP;
            end
         end
         ST_HGAP: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff      <= ST_IDLE;
         ph_ff         <= 4'h0;
         long_ff       <= 1'b0;
         last_rem_ff   <= 1'b1;
         o_a_out       <= 8'h00;
         o_ad_out      <= 8'h00;
         o_a_oe        <= 1'b1;
         o_ad_oe       <= 1'b0;
         o_ale         <= 1'b0;
         o_read_n      <= 1'b1;
         o_cpu_rd_data <= 8'h00;
         o_cpu_rd_done <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         ph_ff         <= nxt_ph;
         o_cpu_rd_done <= 1'b0;
         if (state_ff == ST_IDLE && nxt_state == ST_LRD) begin
            long_ff  <= acr_ff[`DBRA_ACR_LONG_RD];
            o_a_out  <= i_cpu_addr[15:8];
            o_ad_out <= i_cpu_addr[7:0];
         end
         if (state_ff == ST_LRD && nxt_state == ST_LGAP) begin
            o_cpu_rd_data <= ad_s;
            o_cpu_rd_done <= 1'b1;
            last_rem_ff   <= 1'b0;
         end
         if (state_ff == ST_REM && nxt_state == ST_HGAP) begin
            last_rem_ff <= 1'b1;
         end
         o_ale    <= (nxt_state == ST_LRD) && (nxt_ph < ALE_CYC);
         o_ad_oe  <= (nxt_state == ST_LRD) && (nxt_ph < ALE_CYC);
         o_read_n <= ~((nxt_state == ST_LRD) && (nxt_ph >= rd_fall));
         o_a_oe   <= (nxt_state == ST_IDLE) || (nxt_state == ST_LRD) || (nxt_state == ST_LGAP);
      end
   end

   // ==================================================
   // Remote buffered access to configuration, counter and code
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ric_ff           <= `DBRA_RIC_RST;
         rrd_d_ff         <= 1'b0;
         rwr_d_ff         <= 1'b0;
         buf_rd_ff        <= 1'b0;
         byte_hi_ff       <= 1'b0;
         wlo_ff           <= 8'h00;
         iwr_cnt_ff       <= 4'h0;
         sl_cnt_ff        <= 4'h0;
         o_remote_data    <= 8'h00;
         o_remote_data_oe <= 1'b0;
         o_instr_addr     <= 16'h0000;
         o_instr_wdata    <= 16'h0000;
         o_instr_write_n  <= 1'b1;
      end else begin
         rrd_d_ff <= rrd_s;
         rwr_d_ff <= rwr_s;
         if (iwr_cnt_ff != 4'h0) begin
            iwr_cnt_ff <= iwr_cnt_ff - 4'h1;
         end
         o_instr_write_n <= ~(iwr_cnt_ff > 4'h1);
         if (sl_cnt_ff != 4'h0) begin
            sl_cnt_ff <= sl_cnt_ff - 4'h1;
            if (sl_cnt_ff == 4'h1) begin
               o_instr_addr <= o_instr_addr + 16'h0001;
            end
         end
         if (rrd_fall && buf_sel) begin
            buf_rd_ff        <= 1'b1;
            o_remote_data_oe <= 1'b1;
            if (cfg_s) begin
               o_remote_data <= ric_ff;
            end else begin
               case (ms)
                  `DBRA_MS_IMEM:  o_remote_data <= byte_hi_ff ? i_instr_rdata[15:8] : i_instr_rdata[7:0];
                  `DBRA_MS_PC_LO: o_remote_data <= o_instr_addr[7:0];
                  `DBRA_MS_PC_HI: o_remote_data <= o_instr_addr[15:8];
                  default:        o_remote_data <= 8'h00;
               endcase
            end
         end
         if (rrd_rise && buf_rd_ff) begin
            buf_rd_ff        <= 1'b0;
            o_remote_data_oe <= 1'b0;
            if (!cfg_s && ms == `DBRA_MS_IMEM) begin
               byte_hi_ff <= ~byte_hi_ff;
               if (byte_hi_ff) begin
                  o_instr_addr <= o_instr_addr + 16'h0001;
               end
            end
         end
         if (rwr_rise) begin
            if (cfg_s) begin
               ric_ff <= rdat_s;
               if (rdat_s[1:0] == `DBRA_MS_IMEM) begin
                  byte_hi_ff <= 1'b0;
               end
            end else begin
               case (ms)
                  `DBRA_MS_IMEM: begin
                     if (!byte_hi_ff) begin
                        wlo_ff     <= rdat_s;
                        byte_hi_ff <= 1'b1;
                     end else begin
                        o_instr_wdata <= {rdat_s, wlo_ff};
                        byte_hi_ff    <= 1'b0;
                        iwr_cnt_ff    <= IWR_CYC + 4'h1;
                        sl_cnt_ff     <= SL_CYC;
                     end
                  end
                  `DBRA_MS_PC_LO: o_instr_addr[7:0]  <= rdat_s;
                  `DBRA_MS_PC_HI: o_instr_addr[15:8] <= rdat_s;
                  default: ;
               endcase
            end
         end
      end
   end

   // ==================================================
   // Software register port
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         acr_ff      <= `DBRA_ACR_RST;
         idx0_ff     <= `DBRA_IDX_RST;
         idx1_ff     <= `DBRA_IDX_RST;
         o_reg_rdata <= 8'h00;
      end else begin
         if (i_reg_wr) begin
            case (i_reg_addr)
               `DBRA_OFS_ACR:  acr_ff  <= {7'h00, i_reg_wdata[`DBRA_ACR_LONG_RD]};
               `DBRA_OFS_IDX0: idx0_ff <= i_reg_wdata;
               `DBRA_OFS_IDX1: idx1_ff <= i_reg_wdata;
               default: ;
            endcase
         end
         o_reg_rdata <= 8'h00;
         if (i_reg_rd) begin
            case (i_reg_addr)
               `DBRA_OFS_ACR:  o_reg_rdata <= acr_ff;
               `DBRA_OFS_IDX0: o_reg_rdata <= idx0_ff;
               `DBRA_OFS_IDX1: o_reg_rdata <= idx1_ff;
               `DBRA_OFS_STAT: o_reg_rdata <= {2'h0, buf_rd_ff, byte_hi_ff, last_rem_ff,
                                               ~o_a_oe, state_ff == ST_LRD, state_ff == ST_IDLE};
               `DBRA_OFS_RIC:  o_reg_rdata <= ric_ff;
               default:        o_reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // dbra_core
`default_nettype wire

// file: verilog/dbra_map.vh
// Constants for the data bus and remote access timing block
// Function
// - Long-read select set: data memory reads take 4 T-states, read strobe half T later
// - After reset or long-read select cleared: data memory reads take 3 T-states
// - After read strobe rises, wait one T-state before driving the address/data bus
// - Ownership handover of both buses leaves them undriven for half a T-state
// - Soft load advances the instruction address two T-states later, in phase with data
// - Buffered remote reads of config, counter or code drop grant when strobe rises
// - After reset index registers and both bus output values are zero
// - Selecting instruction memory makes the next remote access hit the low byte
// - Select bits: 00 data, 01 instruction, 10 counter low, 11 counter high
// - Simultaneous data memory requests: local first, then the two alternate
// - Remote interface configuration register clears to zero at reset
`ifndef DBRA_MAP_VH
`define DBRA_MAP_VH
// ==================================================
// Register port offsets
`define DBRA_OFS_ACR        3'h0
`define DBRA_OFS_IDX0       3'h1
`define DBRA_OFS_IDX1       3'h2
`define DBRA_OFS_STAT       3'h3
`define DBRA_OFS_RIC        3'h4
// ==================================================
// Field positions and reset values
`define DBRA_ACR_LONG_RD    0
`define DBRA_ACR_RST        8'h00
`define DBRA_RIC_RST        8'h00
`define DBRA_IDX_RST        8'h00
`define DBRA_MS_DMEM        2'h0
`define DBRA_MS_IMEM        2'h1
`define DBRA_MS_PC_LO       2'h2
`define DBRA_MS_PC_HI       2'h3
// ==================================================
// Timing, in half T-states, and cycles per half T-state
`define DBRA_HALF_T_CYC     4'h1
`define DBRA_FAST_RD_HALVES 4'h6
`define DBRA_LONG_RD_HALVES 4'h8
`define DBRA_ALE_HALVES     4'h2
`define DBRA_IWR_HALVES     4'h2
`define DBRA_SOFTLD_HALVES  4'h4
`endif

// file: verilog/dbra_sync.v
// Two-stage synchroniser for pin inputs, one chain per bit
`default_nettype none
module dbra_sync #(
   parameter W   = 1,
   parameter RST = 1'b0
) (
   input  wire         i_clk_sys,  // System clock
   input  wire         i_nrst,     // Async reset, active low
   input  wire [W-1:0] i_d,        // Asynchronous inputs
   output wire [W-1:0] o_q         // Synchronised outputs
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg s1_ff;
         reg s2_ff;
         always @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               s1_ff <= RST;
               s2_ff <= RST;
            end else begin
               s1_ff <= i_d[g];
               s2_ff <= s1_ff;
            end
         end
         assign o_q[g] = s2_ff;
      end
   endgenerate
endmodule // dbra_sync
`default_nettype wire
